/* File: ccs_clock_ctrl.sv */
// Contract
// - With ext enable on, flag ext clock available after the fourth pin pulse.
// - External clock feeds only the CPU clock selector, never a prescaler.
// - While external clock is in use, the crystal path is unavailable.
// - After power-up and every sleep exit, CPU clock comes from RC.
// - Select 0 gives RC; select 1 gives crystal if usable, else external if enabled, else RC.
// - CPU clock source changes let an enabled old source finish its high phase; output then stays low until the new source rises.
// - Routing follows the mode table; disabled sources leave targets off.
// - High prescaler is clocked by RC only while RC is enabled.
// - Low prescaler uses crystal if usable, else high tap when RC runs.
// - Port wake bit sets RC enable once port A bit 0 reads 1.
// - Fast debounce bit picks 8 kHz debouncer clock, else 256 Hz.
// - Crystal clock shows on port B bit 3 when enabled, else 0.
// - CPU clock output bit shows the CPU clock on port B bit 2.
// - High prescaler has 8 stages, low prescaler 15 stages.
// - Divider clear bit or crystal enable set clears low prescaler.
// - Sleep reset clears both prescaler chains asynchronously.
// - Crystal cold flag holds 1 for 37268 crystal cycles after enable.
// - Without crystal, the low prescaler takes the high tap set by the divider tap field.
// - Setting crystal enable is ignored while ext flag or enable is 1.
// - Power-on reset and sleep clear crystal enable and set cold flag.
// - Entering sleep clears the RC enable bit.
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
module ccs_clock_ctrl
    import ccs_pkg::*;
#(
    parameter int COLD_COUNT = COLD_CYCLES
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        sleep_reset,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Oscillator and pin inputs
    input  wire logic        rc_clk,
    input  wire logic        crystal_clk,
    input  wire logic        osc_in_pin,
    input  wire logic        port_a_bit0,
    // Clock outputs
    output logic             cpu_clk,
    output logic             port_b_bit2,
    output logic             port_b_bit3,
    output logic             debounce_clk,
    // Oscillator controls
    output logic             rc_osc_enable,
    output logic             crystal_enable,
    output logic             crystal_cold_flag,
    output logic             ext_clk_available
);

    // ========================================================
    // Input synchronisers
    logic [4:0] in_lvl;
    logic [4:0] in_rise;

    ccs_sync_edge #(.W(5)) u_sync (
        .mclk     (mclk),
        .nrst     (nrst),
        .async_in ({sleep_reset, port_a_bit0, osc_in_pin,
                    crystal_clk, rc_clk}),
        .level    (in_lvl),
        .rise     (in_rise)
    );

    wire rc_lvl   = in_lvl[0];
    wire rc_rise  = in_rise[0];
    wire xt_lvl   = in_lvl[1];
    wire xt_rise  = in_rise[1];
    wire ext_lvl  = in_lvl[2];
    wire ext_rise = in_rise[2];
    wire pa_lvl   = in_lvl[3];
    wire slp      = in_lvl[4];

    // ========================================================
    // AHB-Lite address phase
    logic        wr_pend_r;
    logic [7:0]  addr_r;
    logic [31:0] rd_mux;

    wire acc_ok  = hsel & htrans[1] & hready;
    wire rd_acc  = acc_ok & ~hwrite;
    wire [7:0] a_off = haddr[7:0];
    wire hit     = (haddr[31:8] == 24'h000000);
    wire wr_clk  = wr_pend_r & (addr_r == OFF_CLK);
    wire wr_misc = wr_pend_r & (addr_r == OFF_MISC);
    wire wr_div  = wr_pend_r & (addr_r == OFF_DIV);

    // ========================================================
    // Control registers
    logic cpu_sel_r, rc_r, xtal_r, xtal_q, cold_r;
    logic ext_en_r, ext_av_r, slp_q;
    logic wake_r, debf_r, xout_r, cout_r, deben_r;
    logic [DIV_TAP_W-1:0] tap_sel_r;
    logic [2:0]           ext_cnt_r;
    logic [COLD_W-1:0]    cold_cnt_r;
    logic [HI_STAGES-1:0] hi_cnt_r;
    logic [LO_STAGES-1:0] lo_cnt_r;
    logic                 tap_q;
    logic                 pa_db0_r, pa_db1_r;

    // Setting the crystal enable is blocked while the ext clock owns it
    wire ext_busy   = ext_en_r | ext_av_r;
    wire xtal_start = xtal_r & ~xtal_q;
    wire slp_exit   = ~slp & slp_q;
    wire xtal_ok    = xtal_r & ~ext_busy;

    // Debouncer clock taps from the low chain
    wire deb_tick_src = debf_r ? lo_cnt_r[DEB_FAST_TAP]
                               : lo_cnt_r[DEB_SLOW_TAP];
    logic deb_q;
    wire  deb_tick  = deb_tick_src & ~deb_q;
    wire  pa_ok     = deben_r ? (pa_db0_r & pa_db1_r) : pa_lvl;
    wire  wake_hit  = wake_r & pa_ok;

    wire rc_nxt = slp      ? 1'b0 :
                  (slp_exit | wake_hit) ? 1'b1 :
                  wr_clk   ? hwdata[CLK_RC_BIT] : rc_r;
    wire xtal_nxt = slp    ? 1'b0 :
                    wr_clk ? (hwdata[CLK_XTAL_BIT] &
                              (xtal_r | ~ext_busy))
                           : xtal_r;
    wire sel_nxt  = slp    ? 1'b0 :
                    wr_clk ? hwdata[CLK_SEL_BIT] : cpu_sel_r;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cpu_sel_r <= RST_CPU_SEL;
            rc_r      <= RST_RC_EN;
            xtal_r    <= 1'b0;
            xtal_q    <= 1'b0;
            ext_en_r  <= 1'b0;
            slp_q     <= 1'b0;
            wake_r    <= 1'b0;
            debf_r    <= 1'b0;
            xout_r    <= 1'b0;
            cout_r    <= 1'b0;
            deben_r   <= 1'b0;
            tap_sel_r <= RST_TAP;
        end else begin
            cpu_sel_r <= sel_nxt;
            rc_r      <= rc_nxt;
            xtal_r    <= xtal_nxt;
            xtal_q    <= xtal_r;
            slp_q     <= slp;
            if (wr_clk) begin
                ext_en_r <= hwdata[CLK_EXTEN_BIT];
            end
            if (wr_misc) begin
                wake_r  <= hwdata[MISC_WAKE_BIT];
                debf_r  <= hwdata[MISC_DEBF_BIT];
                xout_r  <= hwdata[MISC_XOUT_BIT];
                cout_r  <= hwdata[MISC_COUT_BIT];
                deben_r <= hwdata[MISC_DEBEN_BIT];
            end
            if (wr_div) begin
                tap_sel_r <= hwdata[DIV_TAP_LSB +: DIV_TAP_W];
            end
        end
    end

    // ========================================================
    // External clock detection
    always_ff @(posedge mclk) begin
        if (!nrst || !ext_en_r) begin
            ext_cnt_r <= 3'h0;
            ext_av_r  <= 1'b0;
        end else if (ext_rise && !ext_av_r) begin
            ext_cnt_r <= ext_cnt_r + 3'h1;
            if (ext_cnt_r == 3'(EXT_PULSES - 1)) begin
                ext_av_r <= 1'b1;
            end
        end
    end

    // ========================================================
    // Crystal start-up masking
    always_ff @(posedge mclk) begin
        if (!nrst || !xtal_r || xtal_start) begin
            cold_r     <= 1'b1;
            cold_cnt_r <= '0;
        end else if (xt_rise && cold_r) begin
            cold_cnt_r <= cold_cnt_r + COLD_W'(1);
            if (cold_cnt_r == COLD_W'(COLD_COUNT - 1)) begin
                cold_r <= 1'b0;
            end
        end
    end

    // ========================================================
    // Prescaler chains, cleared at once by sleep reset
    // Chains count source edges seen at mclk, so a source must
    // stay well below half of mclk.
    wire hi_inc  = rc_r & rc_rise;
    wire hi_tap  = hi_cnt_r[tap_sel_r];
    wire tap_up  = hi_tap & ~tap_q;
    wire lo_inc  = xtal_ok ? xt_rise : (rc_r & tap_up);
    wire lo_clr  = (wr_div & hwdata[DIV_CLR_BIT]) | xtal_start;

    always_ff @(posedge mclk or posedge sleep_reset) begin
        if (sleep_reset) begin
            hi_cnt_r <= '0;
            lo_cnt_r <= '0;
            tap_q    <= 1'b0;
        end else if (!nrst) begin
            hi_cnt_r <= '0;
            lo_cnt_r <= '0;
            tap_q    <= 1'b0;
        end else begin
            tap_q <= hi_tap;
            if (hi_inc) begin
                hi_cnt_r <= hi_cnt_r + HI_STAGES'(1);
            end
            if (lo_clr) begin
                lo_cnt_r <= '0;
            end else if (lo_inc) begin
                lo_cnt_r <= lo_cnt_r + LO_STAGES'(1);
            end
        end
    end

    // ========================================================
    // Port A debouncer: two agreeing ticks accept the level
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            deb_q    <= 1'b0;
            pa_db0_r <= 1'b0;
            pa_db1_r <= 1'b0;
        end else begin
            deb_q <= deb_tick_src;
            if (deb_tick) begin
                pa_db0_r <= pa_lvl;
                pa_db1_r <= pa_db0_r;
            end
        end
    end

    // ========================================================
    // Glitch-free CPU clock switch
    ccs_src_t want_src, cur_r;
    ccs_sw_t  sw_r;
    logic     cpu_clk_nxt;
    logic     cur_lvl, want_lvl;

    // Table routing: select 0 is RC or off, select 1 falls back
    assign want_src = !cpu_sel_r ? (rc_r ? SRC_RC : SRC_OFF) :
                      xtal_ok    ? SRC_XTAL :
                      ext_en_r   ? SRC_EXT :
                      rc_r       ? SRC_RC : SRC_OFF;

    // A disabled source reads low, so a stopped oscillator left high
    // cannot stall the switch or hold the CPU clock up
    always_comb begin
        case (cur_r)
            SRC_RC:   cur_lvl = rc_lvl & rc_r;
            SRC_XTAL: cur_lvl = xt_lvl & xtal_r;
            SRC_EXT:  cur_lvl = ext_lvl & ext_en_r;
            default:  cur_lvl = 1'b0;
        endcase
        case (want_src)
            SRC_RC:   want_lvl = rc_lvl & rc_r;
            SRC_XTAL: want_lvl = xt_lvl & xtal_r;
            SRC_EXT:  want_lvl = ext_lvl & ext_en_r;
            default:  want_lvl = 1'b0;
        endcase
    end

    // Old source runs to its low phase, then output holds low until
    // the new one is low too; that low phase ends when the new one rises.
    assign cpu_clk_nxt = (sw_r == SW_NEW) ? 1'b0 : cur_lvl;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sw_r  <= SW_RUN;
            cur_r <= SRC_RC;
        end else begin
            case (sw_r)
                SW_RUN: begin
                    if (want_src != cur_r) begin
                        sw_r <= SW_OLD;
                    end
                end
                SW_OLD: begin
                    if (!cur_lvl) begin
                        sw_r <= SW_NEW;
                    end
                end
                SW_NEW: begin
                    if (!want_lvl) begin
                        cur_r <= want_src;
                        sw_r  <= SW_RUN;
                    end
                end
                default: sw_r <= SW_RUN;
            endcase
        end
    end

    // ========================================================
    // Registered outputs and read data
    always_comb begin
        rd_mux = 32'h00000000;
        case (a_off)
            OFF_CLK: begin
                rd_mux[CLK_SEL_BIT]   = cpu_sel_r;
                rd_mux[CLK_RC_BIT]    = rc_r;
                rd_mux[CLK_XTAL_BIT]  = xtal_r;
                rd_mux[CLK_COLD_BIT]  = cold_r;
                rd_mux[CLK_EXTEN_BIT] = ext_en_r;
                rd_mux[CLK_EXTAV_BIT] = ext_av_r;
            end
            OFF_MISC: begin
                rd_mux[MISC_WAKE_BIT]  = wake_r;
                rd_mux[MISC_DEBF_BIT]  = debf_r;
                rd_mux[MISC_XOUT_BIT]  = xout_r;
                rd_mux[MISC_COUT_BIT]  = cout_r;
                rd_mux[MISC_DEBEN_BIT] = deben_r;
            end
            OFF_DIV: rd_mux[DIV_TAP_LSB +: DIV_TAP_W] = tap_sel_r;
            OFF_STAT: begin
                rd_mux[STAT_HI_LSB +: HI_STAGES] = hi_cnt_r;
                rd_mux[STAT_LO_LSB +: LO_STAGES] = lo_cnt_r;
            end
            default: rd_mux = 32'h00000000;
        endcase
        if (!hit) begin
            rd_mux = 32'h00000000;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wr_pend_r         <= 1'b0;
            addr_r            <= 8'h00;
            hrdata            <= 32'h00000000;
            hreadyout         <= 1'b1;
            hresp             <= 1'b0;
            cpu_clk           <= 1'b0;
            port_b_bit2       <= 1'b0;
            port_b_bit3       <= 1'b0;
            debounce_clk      <= 1'b0;
            rc_osc_enable     <= RST_RC_EN;
            crystal_enable    <= 1'b0;
            crystal_cold_flag <= 1'b1;
            ext_clk_available <= 1'b0;
        end else begin
            wr_pend_r         <= acc_ok & hwrite & hit;
            addr_r            <= a_off;
            hrdata            <= rd_acc ? rd_mux : 32'h00000000;
            cpu_clk           <= cpu_clk_nxt;
            port_b_bit2       <= cout_r & cpu_clk_nxt;
            port_b_bit3       <= xout_r & xtal_r & xt_lvl;
            debounce_clk      <= deb_tick_src;
            rc_osc_enable     <= rc_r;
            crystal_enable    <= xtal_r;
            crystal_cold_flag <= cold_r;
            ext_clk_available <= ext_av_r;
        end
    end

    // ========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst || sleep_reset);

    a_ext_detect_fourth: assert property (
        $rose(ext_av_r) |-> $past(ext_rise) && $past(ext_cnt_r) == 3'h3)
        else $error("ext flag set without fourth pulse");
    a_ext_clear_flag: assert property (
        $fell(ext_en_r) |=> !ext_av_r && ext_cnt_r == 3'h0)
        else $error("ext flag not cleared with enable");
    a_hi_rc_only: assert property (
        !rc_r |=> $stable(hi_cnt_r))
        else $error("high chain moved without rc");
    a_xtal_set_blocked: assert property (
        ext_busy && !xtal_r |=> !xtal_r)
        else $error("crystal enable set while ext busy");
    a_sleep_to_rc: assert property (
        slp |=> !rc_r && !cpu_sel_r && !xtal_r)
        else $error("sleep did not stop sources");
    a_switch_low_hold: assert property (
        sw_r == SW_NEW |=> !cpu_clk)
        else $error("cpu clock high during switch");
    a_lo_clear_sync: assert property (
        lo_clr |=> lo_cnt_r == '0)
        else $error("low chain not cleared");
    a_cold_start: assert property (
        xtal_start |=> cold_r [*8])
        else $error("cold flag dropped early");
    a_pb3_zero: assert property (
        !xtal_r |=> !port_b_bit3)
        else $error("crystal output while disabled");
    a_wake_rc_set: assert property (
        wake_hit && !slp |=> rc_r ##1 rc_osc_enable)
        else $error("port wake did not enable rc");
    a_sel0_rc: assert property (
        $fell(cpu_sel_r) && rc_r |-> ##[1:60] (cur_r == SRC_RC || !rc_r))
        else $error("select 0 not on rc");

    c_ext_found:  cover property ($rose(ext_av_r));
    c_to_xtal:    cover property (sw_r == SW_NEW ##1 cur_r == SRC_XTAL);
    c_wake:       cover property (wake_hit && !rc_r ##1 rc_r);
    c_cold_done:  cover property ($fell(cold_r));

endmodule

/* File: ccs_pkg.sv */
package ccs_pkg;

    // =========================================================
    // Register map (byte addresses, one word each)
    localparam logic [7:0] OFF_CLK  = 8'h00;  // sys_clock_config
    localparam logic [7:0] OFF_MISC = 8'h04;  // sys_misc_config
    localparam logic [7:0] OFF_DIV  = 8'h08;  // sys_divider_ctrl
    localparam logic [7:0] OFF_STAT = 8'h0C;  // divider status

    // =========================================================
    // sys_clock_config fields
    localparam int CLK_SEL_BIT   = 0;
    localparam int CLK_RC_BIT    = 1;
    localparam int CLK_XTAL_BIT  = 2;
    localparam int CLK_COLD_BIT  = 3;
    localparam int CLK_EXTEN_BIT = 4;
    localparam int CLK_EXTAV_BIT = 5;

    // =========================================================
    // sys_misc_config fields
    localparam int MISC_WAKE_BIT  = 0;
    localparam int MISC_DEBF_BIT  = 1;
    localparam int MISC_XOUT_BIT  = 2;
    localparam int MISC_COUT_BIT  = 3;
    localparam int MISC_DEBEN_BIT = 4;

    // =========================================================
    // sys_divider_ctrl and status fields
    localparam int DIV_CLR_BIT  = 0;
    localparam int DIV_TAP_LSB  = 4;
    localparam int DIV_TAP_W    = 3;
    localparam int STAT_HI_LSB  = 0;
    localparam int STAT_LO_LSB  = 8;

    // =========================================================
    // Reset values
    localparam logic            RST_CPU_SEL = 1'b0;
    localparam logic            RST_RC_EN   = 1'b1;
    localparam logic [DIV_TAP_W-1:0] RST_TAP = 3'h0;

    // =========================================================
    // Sizes and counts
    localparam int HI_STAGES   = 8;
    localparam int LO_STAGES   = 15;
    localparam int EXT_PULSES  = 4;
    localparam int COLD_CYCLES = 37268;
    localparam int COLD_W      = 16;
    localparam int DEB_FAST_TAP = 1;   // 8192 Hz from a 32768 Hz chain
    localparam int DEB_SLOW_TAP = 6;   // 256 Hz from a 32768 Hz chain

    // =========================================================
    // Types
    typedef enum logic [1:0] {
        SRC_OFF  = 2'h0,
        SRC_RC   = 2'h1,
        SRC_XTAL = 2'h2,
        SRC_EXT  = 2'h3
    } ccs_src_t;

    typedef enum logic [1:0] {
        SW_RUN = 2'h0,
        SW_OLD = 2'h1,
        SW_NEW = 2'h3
    } ccs_sw_t;

endpackage

/* File: ccs_sync_edge.sv */
`timescale 1ns/10ps
module ccs_sync_edge #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         nrst,
    // Asynchronous inputs
    input  wire logic [W-1:0] async_in,
    // Synchronised level and rising edge
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~prev_r;

endmodule

/* File: test_clock_source_select_prescalers.sv */
`timescale 1ns/10ps
module test_clock_source_select_prescalers
    import ccs_pkg::*;
;
    // =========================================================
    // Bench signals
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        sleep_reset = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    logic        rc_clk = 1'b0;
    logic        crystal_clk = 1'b0;
    logic        osc_in_pin = 1'b0;
    logic        port_a_bit0 = 1'b0;
    wire         cpu_clk;
    wire         port_b_bit2;
    wire         port_b_bit3;
    wire         debounce_clk;
    wire         rc_osc_enable;
    wire         crystal_enable;
    wire         crystal_cold_flag;
    wire         ext_clk_available;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          rc_cnt = 0;
    int          xt_cnt = 0;
    logic [31:0] rd;
    logic [31:0] s1;
    int          per;
    logic        seen;
    wire  [2:0]  obs = {debounce_clk, port_b_bit3, port_b_bit2};

    always #25 mclk = ~mclk;

    // Short start-up count keeps the crystal test brief
    ccs_clock_ctrl #(.COLD_COUNT(8)) ccs_clock_ctrl_inst (
        .mclk(mclk), .nrst(nrst), .sleep_reset(sleep_reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rc_clk(rc_clk), .crystal_clk(crystal_clk),
        .osc_in_pin(osc_in_pin), .port_a_bit0(port_a_bit0),
        .cpu_clk(cpu_clk), .port_b_bit2(port_b_bit2),
        .port_b_bit3(port_b_bit3), .debounce_clk(debounce_clk),
        .rc_osc_enable(rc_osc_enable), .crystal_enable(crystal_enable),
        .crystal_cold_flag(crystal_cold_flag),
        .ext_clk_available(ext_clk_available)
    );

    // =========================================================
    // Oscillators run only while enabled: RC period 8, crystal 16 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            summarize();
        end
        rc_cnt <= (rc_cnt + 1) % 4;
        xt_cnt <= (xt_cnt + 1) % 8;
        if (rc_osc_enable === 1'b1 && rc_cnt == 3)
            rc_clk <= ~rc_clk;
        if (crystal_enable === 1'b1 && xt_cnt == 7)
            crystal_clk <= ~crystal_clk;
    end

    // =========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask

    task automatic rdr(input logic [7:0] a);
        xfer(1'b0, a, 32'h0, rd);
    endtask

    // Cycles between two rising edges of an observed output
    task automatic period(input int i);
        logic p;
        int   n;
        p = 1'b1;
        n = 0;
        while (n < 5000 && !(p === 1'b0 && obs[i] === 1'b1)) begin
            p = obs[i];
            n++;
            @(posedge mclk);
        end
        per = 0;
        p = 1'b1;
        while (per < 5000 && !(p === 1'b0 && obs[i] === 1'b1)) begin
            p = obs[i];
            per++;
            @(posedge mclk);
        end
    endtask

    task automatic pulse();
        osc_in_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        osc_in_pin <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // =========================================================
    // Tests
    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rdr(OFF_CLK);
        chk("clk reset", rd, 32'h0000000A);
        chk("rc port", rc_osc_enable, 1'b1);
        chk("cold port", crystal_cold_flag, 1'b1);
        rdr(8'h10);
        chk("unmapped", rd, 32'h0);
        chk("hresp", hresp, 1'b0);
        chk("hready", hreadyout, 1'b1);
        $display("test reset done");

        wr(OFF_MISC, 32'h8);
        period(0);
        chk("cpu rc period", per, 8);
        period(2);
        chk("slow debounce", per, 2048);
        wr(OFF_MISC, 32'hA);
        period(2);
        chk("fast debounce", per, 64);
        $display("test rc done");

        wr(OFF_CLK, 32'h12);
        wr(OFF_CLK, 32'h16);
        rdr(OFF_CLK);
        chk("xtal refused", rd, 32'h1A);
        repeat (3) pulse();
        repeat (6) @(posedge mclk);
        chk("ext after 3", ext_clk_available, 1'b0);
        pulse();
        repeat (6) @(posedge mclk);
        chk("ext after 4", ext_clk_available, 1'b1);
        wr(OFF_CLK, 32'h02);
        repeat (3) @(posedge mclk);
        chk("ext cleared", ext_clk_available, 1'b0);
        $display("test external done");

        wr(OFF_CLK, 32'h06);
        rdr(OFF_CLK);
        chk("cold early", rd, 32'h0E);
        chk("xtal port", crystal_enable, 1'b1);
        wr(OFF_MISC, 32'h4);
        repeat (200) @(posedge mclk);
        rdr(OFF_CLK);
        chk("cold done", rd, 32'h06);
        period(1);
        chk("xtal out", per, 16);
        wr(OFF_CLK, 32'h07);
        wr(OFF_MISC, 32'hC);
        // Let the source switch finish before timing the new clock
        repeat (40) @(posedge mclk);
        period(0);
        chk("cpu xtal", per, 16);
        wr(OFF_DIV, 32'h1);
        rdr(OFF_STAT);
        chk("low clear", rd[22:8] < 15'd2, 1'b1);
        wr(OFF_CLK, 32'h06);
        wr(OFF_CLK, 32'h02);
        // Output pin lags the enable bit by one register stage
        repeat (2) @(posedge mclk);
        seen = 1'b0;
        repeat (40) begin
            @(posedge mclk);
            seen = seen | (port_b_bit3 !== 1'b0);
        end
        chk("xtal out off", seen, 1'b0);
        $display("test crystal done");

        sleep_reset <= 1'b1;
        repeat (4) @(posedge mclk);
        rdr(OFF_STAT);
        chk("chains cleared", rd, 32'h0);
        rdr(OFF_CLK);
        chk("sleep bits", rd, 32'h08);
        sleep_reset <= 1'b0;
        repeat (4) @(posedge mclk);
        rdr(OFF_CLK);
        chk("sleep exit", rd, 32'h0A);
        $display("test sleep done");

        wr(OFF_MISC, 32'h1);
        wr(OFF_CLK, 32'h0);
        repeat (4) @(posedge mclk);
        rdr(OFF_STAT);
        s1 = rd;
        repeat (40) @(posedge mclk);
        rdr(OFF_STAT);
        chk("high idle", rd[7:0], s1[7:0]);
        chk("cpu off", cpu_clk, 1'b0);
        port_a_bit0 <= 1'b1;
        repeat (8) @(posedge mclk);
        rdr(OFF_CLK);
        chk("wake rc", rd, 32'h0A);
        $display("test wake done");
        summarize();
    end
endmodule
